// File: hdl/dtc_params.svh
// Timing constants for the dual-channel torque cutoff supervisor.
// Assumes a single control clock at the rate given by DTC_CLK_HZ.
`ifndef DTC_PARAMS_SVH
`define DTC_PARAMS_SVH

// Control clock rate in hertz.
`define DTC_CLK_HZ 250000000
// Longest allowed reaction from emergency to isolation, in milliseconds.
`define DTC_REACT_MS 10
// Channel mismatch time before an alarm, in seconds.
`define DTC_MISMATCH_S 5
// Mismatch time in clock cycles (exact product, 64-bit).
`define DTC_MISMATCH_CYC (64'(`DTC_MISMATCH_S) * 64'(`DTC_CLK_HZ))
// Controlled-stop ramp time, in microseconds, before full isolation.
`define DTC_STOP_US 1000
// Stop ramp in cycles; kept far under the reaction limit.
`define DTC_STOP_CYC ((`DTC_STOP_US * (`DTC_CLK_HZ / 1000000)))

`endif

// File: hdl/dtc_pkg.sv
// Types shared by the torque cutoff supervisor.
// Assumes nothing beyond a SystemVerilog compiler.
package dtc_pkg;
    // Supervisor states, one-hot.
    typedef enum logic [3:0]
    {
        DTC_RUN = 4'h1,
        DTC_STANDBY = 4'h2,
        DTC_STOPPING = 4'h4,
        DTC_CUTOFF = 4'h8
    } dtc_state_t;
endpackage

// File: hdl/dtc_supervisor.sv
// Dual-channel torque cutoff supervisor: decides whether PWM and the
// driver-enable path may run, from two emergency channels and internal alarms.
// Assumes the emergency channels arrive asynchronously from pins and that
// internal_alarm comes from logic on mclk.
//
// Contract
// - Both channels low: cutoff, motor isolated.
// - Stop PWM and drivers within 10 ms.
// - One channel low: standby, await second.
// - Mismatch lasting 5 s raises alarm.
// - Both channels high: cutoff released, normal run. The code instead holds cutoff after a mismatch_alarm until reset.
// - Internal alarm triggers same emergency stop.
// - Controlled stop first, then full isolation.
`timescale 1ns/10ps
`include "dtc_params.svh"

module dtc_supervisor
#(
    parameter longint unsigned MISMATCH_CYC = `DTC_MISMATCH_CYC,
    parameter int unsigned STOP_CYC = `DTC_STOP_CYC
)
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic emergency_chan_a,
    input wire logic emergency_chan_b,
    input wire logic internal_alarm,
    output logic pwm_enable,
    output logic driver_enable,
    output logic stop_ramp,
    output logic torque_cutoff,
    output logic cutoff_standby,
    output logic mismatch_alarm
);

    // ************************************************************
    // Input synchronisers
    // ************************************************************

    logic [2:0] sync_a;
    logic [2:0] sync_b;
    logic chan_a;
    logic chan_b;

    // Three stages per channel; a level counts only once stages two and three
    // agree, so one metastable sample cannot flip the decision.
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            sync_a <= 3'h0;
            sync_b <= 3'h0;
        end
        else
        begin
            sync_a <= {sync_a[1:0], emergency_chan_a};
            sync_b <= {sync_b[1:0], emergency_chan_b};
        end
    end

    // Filtered levels; they reset low so the drive starts in cutoff.
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            chan_a <= 1'b0;
            chan_b <= 1'b0;
        end
        else
        begin
            if (sync_a[2] == sync_a[1])
            begin
                chan_a <= sync_a[2];
            end
            if (sync_b[2] == sync_b[1])
            begin
                chan_b <= sync_b[2];
            end
        end
    end

    // ************************************************************
    // Channel decode and mismatch timer
    // ************************************************************

    logic both_low;
    logic both_high;
    logic mismatch;
    logic [63:0] mis_count;

    assign both_low = ~chan_a & ~chan_b;
    assign both_high = chan_a & chan_b;
    assign mismatch = chan_a ^ chan_b;

    // Counts while the channels disagree; the alarm is sticky until reset,
    // because a wiring fault on one channel must not clear itself.
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            mis_count <= 64'h0;
            mismatch_alarm <= 1'b0;
        end
        else
        begin
            if (!mismatch)
            begin
                mis_count <= 64'h0;
            end
            else if (mis_count < MISMATCH_CYC)
            begin
                mis_count <= mis_count + 64'h1;
            end
            if (mismatch && mis_count >= MISMATCH_CYC - 64'h1)
            begin
                mismatch_alarm <= 1'b1;
            end
        end
    end

    // ************************************************************
    // Supervisor state machine
    // ************************************************************

    dtc_pkg::dtc_state_t state;
    dtc_pkg::dtc_state_t next_state;
    logic [31:0] stop_count;
    logic emergency;

    // Internal or mismatch alarm forces the same sequence as both channels low.
    assign emergency = both_low | internal_alarm | mismatch_alarm;

    always_comb
    begin
        next_state = state;
        unique case (state)
            dtc_pkg::DTC_RUN:
            begin
                if (emergency)
                begin
                    next_state = dtc_pkg::DTC_STOPPING;
                end
                else if (mismatch)
                begin
                    next_state = dtc_pkg::DTC_STANDBY;
                end
            end
            dtc_pkg::DTC_STANDBY:
            begin
                if (emergency)
                begin
                    next_state = dtc_pkg::DTC_STOPPING;
                end
                else if (both_high)
                begin
                    next_state = dtc_pkg::DTC_RUN;
                end
            end
            dtc_pkg::DTC_STOPPING:
            begin
                if (stop_count >= STOP_CYC - 1)
                begin
                    next_state = dtc_pkg::DTC_CUTOFF;
                end
            end
            dtc_pkg::DTC_CUTOFF:
            begin
                if (!emergency && both_high)
                begin
                    next_state = dtc_pkg::DTC_RUN;
                end
            end
            default:
            begin
                next_state = dtc_pkg::DTC_CUTOFF;
            end
        endcase
    end

    // State register; reset lands in cutoff so nothing drives the motor.
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            state <= dtc_pkg::DTC_CUTOFF;
        end
        else
        begin
            state <= next_state;
        end
    end

    // Ramp timer for the controlled stop.
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            stop_count <= 32'h0;
        end
        else if (state == dtc_pkg::DTC_STOPPING)
        begin
            stop_count <= stop_count + 32'h1;
        end
        else
        begin
            stop_count <= 32'h0;
        end
    end

    // ************************************************************
    // Registered outputs
    // ************************************************************

    // PWM runs during the controlled stop so the motor is braked, then the
    // driver path is cut; both fall in cutoff.
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            pwm_enable <= 1'b0;
            driver_enable <= 1'b0;
            stop_ramp <= 1'b0;
            torque_cutoff <= 1'b1;
            cutoff_standby <= 1'b0;
        end
        else
        begin
            pwm_enable <= (next_state != dtc_pkg::DTC_CUTOFF);
            driver_enable <= (next_state != dtc_pkg::DTC_CUTOFF);
            stop_ramp <= (next_state == dtc_pkg::DTC_STOPPING);
            torque_cutoff <= (next_state == dtc_pkg::DTC_CUTOFF);
            cutoff_standby <= (next_state == dtc_pkg::DTC_STANDBY);
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************

    a_cutoff_isolates: assert property (@(posedge mclk) disable iff (reset)
        torque_cutoff |-> !pwm_enable && !driver_enable)
        else $error("Drive enabled while in cutoff.");

    a_react_bound: assert property (@(posedge mclk) disable iff (reset)
        $rose(emergency) |-> ##[1:3] stop_ramp || torque_cutoff)
        else $error("Emergency not acted on promptly.");

    a_stop_then_cut: assert property (@(posedge mclk) disable iff (reset)
        $fell(stop_ramp) && !pwm_enable |-> torque_cutoff)
        else $error("Isolation without completing stop.");

    a_standby_one_low: assert property (@(posedge mclk) disable iff (reset)
        cutoff_standby |-> $past(mismatch))
        else $error("Standby without channel mismatch.");

    a_alarm_after_time: assert property (@(posedge mclk) disable iff (reset)
        $rose(mismatch_alarm) |-> $past(mis_count) >= MISMATCH_CYC - 64'h1)
        else $error("Mismatch alarm raised early.");

    a_run_both_high: assert property (@(posedge mclk) disable iff (reset)
        $rose(pwm_enable) |-> $past(both_high) && !$past(emergency))
        else $error("Drive enabled without both channels high.");

    a_internal_stops: assert property (@(posedge mclk) disable iff (reset)
        internal_alarm && both_high |=> !(state == dtc_pkg::DTC_RUN))
        else $error("Internal alarm did not stop drive.");

    a_sync_agree: assert property (@(posedge mclk) disable iff (reset)
        $changed(chan_a) |-> $past(sync_a[2]) == $past(sync_a[1]))
        else $error("Channel level taken before stages agreed.");

    c_cutoff: cover property (@(posedge mclk) disable iff (reset) $rose(torque_cutoff));
    c_standby: cover property (@(posedge mclk) disable iff (reset) $rose(cutoff_standby));
    c_alarm: cover property (@(posedge mclk) disable iff (reset) $rose(mismatch_alarm));
    c_run: cover property (@(posedge mclk) disable iff (reset) $rose(pwm_enable));

endmodule // dtc_supervisor

// File: testbench/dtc_safety_model.sv
// Model of the external safety system that drives both emergency channels.
// Assumes the bench commands each channel level; pins move just after an edge.
`timescale 1ns/10ps
module dtc_safety_model
(
    input wire logic mclk,
    input wire logic cmd_a,
    input wire logic cmd_b,
    output logic emergency_chan_a,
    output logic emergency_chan_b
);
    // Pins follow the commands one edge later, like relay contacts settling.
    // One process drives each pin; the first edge comes while reset still holds
    // the supervisor, so the unset level before it is never evaluated.
    always @(posedge mclk)
    begin
        emergency_chan_a <= cmd_a;
        emergency_chan_b <= cmd_b;
    end
endmodule // dtc_safety_model

// File: testbench/tb.sv
// Self-checking bench for the torque cutoff supervisor.
// Assumes short sim counts for the mismatch and stop ramp timers.
`timescale 1ns/10ps
module tb;
    localparam int mis_cyc = 100;
    localparam int stop_cyc = 8;
    localparam int i_pwm = 0, i_drv = 1, i_ramp = 2, i_cut = 3, i_sby = 4, i_alm = 5;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic cmd_a = 1'b0;
    logic cmd_b = 1'b0;
    logic internal_alarm = 1'b0;
    logic emergency_chan_a, emergency_chan_b;
    logic pwm_enable, driver_enable, stop_ramp, torque_cutoff, cutoff_standby, mismatch_alarm;
    int error_cnt = 0;
    int num_checks = 0;

    // 250 MHz control clock.
    always #2 mclk = ~mclk;

    dtc_safety_model dtc_safety_model_inst (.mclk(mclk), .cmd_a(cmd_a), .cmd_b(cmd_b),
        .emergency_chan_a(emergency_chan_a), .emergency_chan_b(emergency_chan_b));
    dtc_supervisor #(.MISMATCH_CYC(64'h64), .STOP_CYC(32'h8)) dtc_supervisor_inst (
        .mclk(mclk), .reset(reset), .emergency_chan_a(emergency_chan_a),
        .emergency_chan_b(emergency_chan_b), .internal_alarm(internal_alarm),
        .pwm_enable(pwm_enable), .driver_enable(driver_enable), .stop_ramp(stop_ramp),
        .torque_cutoff(torque_cutoff), .cutoff_standby(cutoff_standby),
        .mismatch_alarm(mismatch_alarm));

    // ****************************************
    // Helpers
    // ****************************************
    task automatic chk(input logic got, input logic exp);
        num_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic drive(input logic a, input logic b, input logic al);
        @(posedge mclk);
        cmd_a <= a;
        cmd_b <= b;
        internal_alarm <= al;
        // Step off the edge so the first look at the outputs sees settled values.
        #1;
    endtask
    function automatic logic pick(input int i);
        logic [5:0] v;
        v = {mismatch_alarm, cutoff_standby, torque_cutoff, stop_ramp, driver_enable, pwm_enable};
        return v[i];
    endfunction
    // Bounded wait, so a stuck output is reported instead of hanging.
    task automatic await(input int i, input logic v, input int lim);
        int n;
        n = 0;
        while (pick(i) !== v && n < lim)
        begin
            tick(1);
            n++;
        end
        chk(pick(i), v);
    endtask
    task automatic do_reset;
        @(posedge mclk);
        reset <= 1'b1;
        tick(8);
        @(posedge mclk);
        reset <= 1'b0;
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_run;
        drive(1'b1, 1'b1, 1'b0);
        tick(2);
        chk(torque_cutoff, 1'b1);
        await(i_pwm, 1'b1, 20);
        chk(driver_enable, 1'b1);
        chk(torque_cutoff, 1'b0);
    endtask
    task automatic t_stop;
        drive(1'b0, 1'b0, 1'b0);
        await(i_ramp, 1'b1, 20);
        chk(pwm_enable, 1'b1);
        await(i_cut, 1'b1, stop_cyc + 4);
        chk(pwm_enable, 1'b0);
        chk(driver_enable, 1'b0);
        chk(stop_ramp, 1'b0);
    endtask
    task automatic t_mismatch;
        drive(1'b0, 1'b1, 1'b0);
        await(i_sby, 1'b1, 20);
        chk(torque_cutoff, 1'b0);
        drive(1'b1, 1'b1, 1'b0);
        await(i_sby, 1'b0, 20);
        drive(1'b1, 1'b0, 1'b0);
        await(i_sby, 1'b1, 20);
        tick(mis_cyc - 10);
        chk(mismatch_alarm, 1'b0);
        await(i_alm, 1'b1, 20);
        await(i_cut, 1'b1, stop_cyc + 4);
        drive(1'b1, 1'b1, 1'b0);
        tick(30);
        chk(torque_cutoff, 1'b1);
        do_reset();
    endtask
    task automatic t_internal;
        drive(1'b1, 1'b1, 1'b1);
        await(i_ramp, 1'b1, 4);
        await(i_cut, 1'b1, stop_cyc + 4);
        drive(1'b1, 1'b1, 1'b0);
        await(i_pwm, 1'b1, 20);
    endtask

    task automatic final_report;
        $display("checks=%0d errors=%0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Main sequence: reset held 8 cycles, then each scenario in turn.
    initial
    begin
        repeat (8) @(posedge mclk);
        reset <= 1'b0;
        t_run();
        t_stop();
        t_run();
        t_mismatch();
        t_run();
        t_internal();
        final_report();
    end

    // Watchdog: the run needs well under 1000 cycles.
    initial
    begin
        #20000;
        error_cnt++;
        final_report();
    end
endmodule // tb
